// File: hdl/aer_pkg.sv
package aer_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_UNC_FLAGS = 12'h104;
    localparam logic [11:0] OFS_UNC_SUPPRESS = 12'h108;
    localparam logic [11:0] OFS_UNC_FATALITY = 12'h10C;
    localparam logic [11:0] OFS_COR_FLAGS = 12'h110;
    localparam logic [11:0] OFS_COR_SUPPRESS = 12'h114;
    localparam logic [11:0] OFS_CAP_CTRL = 12'h118;
    localparam logic [11:0] OFS_HDR_WORD0 = 12'h11C;
    localparam logic [11:0] OFS_HDR_WORD3 = 12'h128;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h140;
    localparam logic [11:0] OFS_IRQ_CLEAR = 12'h144;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h148;

    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] UNC_IMPL_MASK = 32'h001FF010;
    localparam logic [31:0] COR_IMPL_MASK = 32'h000031C1;
    localparam logic [31:0] UNC_FATALITY_RST = 32'h00062010;
    localparam logic [31:0] CAP_CTRL_RW_MASK = 32'h00000140;
    localparam int PTR_LSB = 0;
    localparam int PTR_W = 5;
    localparam int BIT_GEN_CAPABLE = 5;
    localparam int BIT_CHK_CAPABLE = 7;
    localparam int BIT_CRC_GEN_EN = 6;
    localparam int BIT_CRC_CHK_EN = 8;
    localparam int HDR_WORDS = 4;
    localparam int IRQ_W = 4;
    localparam int IRQ_UNC_FATAL = 0;
    localparam int IRQ_UNC_NONFATAL = 1;
    localparam int IRQ_COR = 2;
    localparam int IRQ_LOG = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic unsup_req;
        logic crc_err;
        logic malformed;
        logic rx_overflow;
        logic unexp_cpl;
        logic cpl_abort_tx;
        logic cpl_timeout;
        logic fc_proto;
        logic poisoned;
        logic dl_proto;
    } aer_unc_evt_t;

    typedef struct packed {
        logic advisory;
        logic replay_timeout;
        logic replay_rollover;
        logic bad_dllp;
        logic bad_tlp;
        logic rx_err;
    } aer_cor_evt_t;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
        logic correctable;
    } aer_report_t;

endpackage : aer_pkg

// File: hdl/aer_fp.sv
`timescale 1ns/1ps
`default_nettype none
// lowest set bit index of a 32-bit vector, registered
module aer_fp (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // vector in, index out
    input wire logic [31:0] vec,
    output logic found,
    output logic [4:0] index
);
    typedef struct packed {
        logic found;
        logic [4:0] index;
    } aer_fp_state_t;

    aer_fp_state_t st_reg;
    aer_fp_state_t st_next;

    always_comb begin
        st_next = '0;
        for (int i = 31; i >= 0; i--) begin
            if (vec[i]) begin
                st_next.found = 1'b1;
                st_next.index = 5'(i);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign found = st_reg.found;
    assign index = st_reg.index;
endmodule : aer_fp
`default_nettype wire

// File: hdl/aer_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - unsupported request sets uncorrectable flag bit 20
// - end-to-end CRC error sets bit 19, malformed TLP sets bit 18
// - receiver overflow sets bit 17, unexpected completion sets bit 16
// - completer abort sent sets bit 15, completion timeout sets bit 14
// - flow control error bit 13, poisoned TLP bit 12, link protocol bit 4
// - flags reset to zero, clear only by writing one to them
// - uncorrectable flags record errors even when suppressed; they do not decide forwarding
// - uncorrectable suppress bits read-write, reset zero, block reporting
// - fatality bit 0 reports fatal, 1 reports non-fatal
// - fatality resets to one for bits 18, 17, 13, 4; rest zero
// - advisory bit 13, replay timeout bit 12, replay rollover bit 8
// - bad DLLP bit 7, bad TLP bit 6, receiver error bit 0
// - correctable suppress bits read-write, reset zero, mask the error
// - control: sticky pointer 4:0, capable flags 5,7, enables 6,8
// - first unsuppressed uncorrectable error captures first four header words (16 bytes) into the log
// - header byte 0 sits in log bits 31:24
// - four log words at 0x11C to 0x128, sticky, read-only, reset zero
module aer_regs #(
    parameter logic GEN_CAPABLE = 1'b0,
    parameter logic CHK_CAPABLE = 1'b0
) (
    // clock and resets
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sticky_rst_b,
    // detected error events, one-cycle pulses
    input wire aer_pkg::aer_unc_evt_t unc_evt,
    input wire aer_pkg::aer_cor_evt_t cor_evt,
    input wire logic [127:0] rx_hdr,
    // reports toward the root port, CRC enables and interrupt
    output logic report_fatal,
    output logic report_nonfatal,
    output logic report_cor,
    output logic crc_gen_en,
    output logic crc_chk_en,
    output logic irq,
    // axi4-lite write address
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    // axi4-lite write data
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // axi4-lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read address
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    // axi4-lite read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] unc_flags;
        logic [31:0] unc_sup;
        logic [31:0] unc_fat;
        logic [31:0] cor_flags;
        logic [31:0] cor_sup;
        logic [31:0] ctrl;
        logic [aer_pkg::IRQ_W-1:0] irq_stat;
        logic [aer_pkg::IRQ_W-1:0] irq_en;
        logic aw_held;
        logic [11:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic fatal;
        logic nonfatal;
        logic cor;
        logic irq;
    } aer_state_t;

    // sticky part survives rst_b, only sticky_rst_b clears it
    typedef struct packed {
        logic armed;
        logic load;
        logic [aer_pkg::PTR_W-1:0] ptr;
        logic [aer_pkg::HDR_WORDS-1:0][31:0] log;
    } aer_sticky_t;

    aer_state_t st_reg;
    aer_state_t st_next;
    aer_sticky_t sk_reg;
    aer_sticky_t sk_next;
    logic [31:0] unc_raw;
    logic [31:0] cor_raw;
    logic [31:0] unc_fresh;
    logic fp_found;
    logic [4:0] fp_index;

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
            input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction : strb_merge

    // events placed at their flag positions
    always_comb begin
        unc_raw = '0;
        unc_raw[20] = unc_evt.unsup_req;
        unc_raw[19] = unc_evt.crc_err;
        unc_raw[18] = unc_evt.malformed;
        unc_raw[17] = unc_evt.rx_overflow;
        unc_raw[16] = unc_evt.unexp_cpl;
        unc_raw[15] = unc_evt.cpl_abort_tx;
        unc_raw[14] = unc_evt.cpl_timeout;
        unc_raw[13] = unc_evt.fc_proto;
        unc_raw[12] = unc_evt.poisoned;
        unc_raw[4] = unc_evt.dl_proto;
        cor_raw = '0;
        cor_raw[13] = cor_evt.advisory;
        cor_raw[12] = cor_evt.replay_timeout;
        cor_raw[8] = cor_evt.replay_rollover;
        cor_raw[7] = cor_evt.bad_dllp;
        cor_raw[6] = cor_evt.bad_tlp;
        cor_raw[0] = cor_evt.rx_err;
    end

    assign unc_fresh = unc_raw & ~st_reg.unc_sup;

    // lowest unmasked event index; one cycle late, so the header is
    // latched on the event cycle and only the index trails by a cycle
    aer_fp u_fp (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .vec(unc_fresh),
        .found(fp_found),
        .index(fp_index)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic aw_now;
        logic w_now;
        logic do_wr;
        logic [11:0] wa;
        logic [31:0] wd;
        logic [31:0] w1c;
        logic [31:0] rd;
        logic rd_ok;
        logic wr_ok;
        logic log_take;
        logic [aer_pkg::IRQ_W-1:0] irq_evt;
        logic [aer_pkg::IRQ_W-1:0] irq_clr;
        logic [31:0] unc_rep;
        logic [31:0] cor_rep;
        st_next = st_reg;
        sk_next = sk_reg;
        rd = '0;
        rd_ok = 1'b1;
        aw_now = s_awvalid && !st_reg.aw_held;
        w_now = s_wvalid && !st_reg.w_held;
        irq_clr = '0;
        w1c = '0;
        wr_ok = 1'b1;
        // capture address and data in either order
        if (aw_now) begin
            st_next.aw_held = 1'b1;
            st_next.awaddr = s_awaddr;
        end
        if (w_now) begin
            st_next.w_held = 1'b1;
            st_next.wdata = s_wdata;
            st_next.wstrb = s_wstrb;
        end
        do_wr = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
        wa = {st_reg.awaddr[11:2], 2'b00};
        wd = strb_merge(32'h00000000, st_reg.wdata, st_reg.wstrb);
        if (do_wr) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            case (wa)
                aer_pkg::OFS_UNC_FLAGS: w1c = wd;
                aer_pkg::OFS_UNC_SUPPRESS: st_next.unc_sup = aer_pkg::
                    UNC_IMPL_MASK & strb_merge(st_reg.unc_sup,
                    st_reg.wdata, st_reg.wstrb);
                aer_pkg::OFS_UNC_FATALITY: st_next.unc_fat = aer_pkg::
                    UNC_IMPL_MASK & strb_merge(st_reg.unc_fat,
                    st_reg.wdata, st_reg.wstrb);
                aer_pkg::OFS_COR_FLAGS: ;
                aer_pkg::OFS_COR_SUPPRESS: st_next.cor_sup = aer_pkg::
                    COR_IMPL_MASK & strb_merge(st_reg.cor_sup,
                    st_reg.wdata, st_reg.wstrb);
                aer_pkg::OFS_CAP_CTRL: st_next.ctrl = aer_pkg::
                    CAP_CTRL_RW_MASK & strb_merge(st_reg.ctrl,
                    st_reg.wdata, st_reg.wstrb);
                aer_pkg::OFS_IRQ_CLEAR: irq_clr = wd[aer_pkg::IRQ_W-1:0];
                aer_pkg::OFS_IRQ_ENABLE: st_next.irq_en =
                    wd[aer_pkg::IRQ_W-1:0];
                default: begin
                    // read-only registers take writes silently
                    wr_ok = (wa >= aer_pkg::OFS_HDR_WORD0 &&
                        wa <= aer_pkg::OFS_HDR_WORD3) ||
                        wa == aer_pkg::OFS_IRQ_STATUS;
                end
            endcase
            st_next.bresp = wr_ok ? aer_pkg::RESP_OKAY
                                  : aer_pkg::RESP_SLVERR;
        end
        if (st_reg.bvalid && s_bready) begin
            st_next.bvalid = 1'b0;
        end

        // flags: set wins over a same-cycle clear
        st_next.unc_flags = (((wa == aer_pkg::OFS_UNC_FLAGS) ?
            st_reg.unc_flags & ~w1c : st_reg.unc_flags) | unc_raw) &
            aer_pkg::UNC_IMPL_MASK;
        st_next.cor_flags = (((do_wr && wa == aer_pkg::OFS_COR_FLAGS) ?
            st_reg.cor_flags & ~wd : st_reg.cor_flags) | cor_raw) &
            aer_pkg::COR_IMPL_MASK;

        // first error: log the header on the event cycle
        log_take = sk_reg.armed && (|unc_fresh);
        if (log_take) begin
            for (int k = 0; k < aer_pkg::HDR_WORDS; k++) begin
                sk_next.log[k] = rx_hdr[127-32*k -: 32];
            end
            sk_next.armed = 1'b0;
        end
        // pointer trails the log by one cycle, from the registered index
        sk_next.load = log_take;
        if (sk_reg.load && fp_found) begin
            sk_next.ptr = fp_index;
        end
        // re-arm when software clears the flag the pointer names
        if (!sk_reg.armed && !sk_reg.load &&
                !st_reg.unc_flags[sk_reg.ptr]) begin
            sk_next.armed = 1'b1;
        end

        // forwarded reports, qualified by suppress bits
        unc_rep = unc_raw & ~st_reg.unc_sup;
        cor_rep = cor_raw & ~st_reg.cor_sup;
        st_next.fatal = |(unc_rep & ~st_reg.unc_fat);
        st_next.nonfatal = |(unc_rep & st_reg.unc_fat);
        st_next.cor = |cor_rep;

        irq_evt = '0;
        irq_evt[aer_pkg::IRQ_UNC_FATAL] = st_next.fatal;
        irq_evt[aer_pkg::IRQ_UNC_NONFATAL] = st_next.nonfatal;
        irq_evt[aer_pkg::IRQ_COR] = st_next.cor;
        irq_evt[aer_pkg::IRQ_LOG] = log_take;
        st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_evt;
        st_next.irq = |(st_next.irq_stat & st_next.irq_en);

        // read channel
        if (s_arvalid && !st_reg.rvalid) begin
            case ({s_araddr[11:2], 2'b00})
                aer_pkg::OFS_UNC_FLAGS: rd = st_reg.unc_flags;
                aer_pkg::OFS_UNC_SUPPRESS: rd = st_reg.unc_sup;
                aer_pkg::OFS_UNC_FATALITY: rd = st_reg.unc_fat;
                aer_pkg::OFS_COR_FLAGS: rd = st_reg.cor_flags;
                aer_pkg::OFS_COR_SUPPRESS: rd = st_reg.cor_sup;
                aer_pkg::OFS_CAP_CTRL: begin
                    rd = st_reg.ctrl;
                    rd[aer_pkg::PTR_LSB +: aer_pkg::PTR_W] = sk_reg.ptr;
                    rd[aer_pkg::BIT_GEN_CAPABLE] = GEN_CAPABLE;
                    rd[aer_pkg::BIT_CHK_CAPABLE] = CHK_CAPABLE;
                end
                aer_pkg::OFS_IRQ_STATUS: rd = 32'(st_reg.irq_stat);
                aer_pkg::OFS_IRQ_ENABLE: rd = 32'(st_reg.irq_en);
                aer_pkg::OFS_IRQ_CLEAR: rd = '0;
                default: begin
                    if ({s_araddr[11:2], 2'b00} >= aer_pkg::OFS_HDR_WORD0
                            && {s_araddr[11:2], 2'b00} <=
                            aer_pkg::OFS_HDR_WORD3) begin
                        rd = sk_reg.log[2'(s_araddr[11:2] -
                            aer_pkg::OFS_HDR_WORD0[11:2])];
                    end else begin
                        rd_ok = 1'b0;
                    end
                end
            endcase
            st_next.rvalid = 1'b1;
            st_next.rdata = rd;
            st_next.rresp = rd_ok ? aer_pkg::RESP_OKAY
                                  : aer_pkg::RESP_SLVERR;
        end else if (st_reg.rvalid && s_rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.unc_fat <= aer_pkg::UNC_FATALITY_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clk_sys or negedge sticky_rst_b) begin
        if (!sticky_rst_b) begin
            sk_reg <= '0;
            sk_reg.armed <= 1'b1;
        end else begin
            sk_reg <= sk_next;
        end
    end

    assign s_awready = !st_reg.aw_held;
    assign s_wready = !st_reg.w_held;
    assign s_bvalid = st_reg.bvalid;
    assign s_bresp = st_reg.bresp;
    assign s_arready = !st_reg.rvalid;
    assign s_rvalid = st_reg.rvalid;
    assign s_rdata = st_reg.rdata;
    assign s_rresp = st_reg.rresp;
    assign report_fatal = st_reg.fatal;
    assign report_nonfatal = st_reg.nonfatal;
    assign report_cor = st_reg.cor;
    assign crc_gen_en = st_reg.ctrl[aer_pkg::BIT_CRC_GEN_EN];
    assign crc_chk_en = st_reg.ctrl[aer_pkg::BIT_CRC_CHK_EN];
    assign irq = st_reg.irq;
endmodule : aer_regs
`default_nettype wire

// File: dv/aer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module aer_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // events and reports
    input wire aer_pkg::aer_unc_evt_t unc_evt,
    input wire aer_pkg::aer_cor_evt_t cor_evt,
    input wire logic report_fatal,
    input wire logic report_nonfatal,
    input wire logic report_cor,
    input wire logic crc_gen_en,
    input wire logic crc_chk_en,
    input wire logic irq,
    // bus handshakes
    input wire logic s_wvalid,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [1:0] s_bresp,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready
);
    logic act;
    assign act = report_fatal | report_nonfatal | report_cor | (|unc_evt)
        | (|cor_evt) | s_bvalid;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    fatal_cause_a: assert property (report_fatal |-> |$past(unc_evt))
        else $error("fatal report without an event");
    nonfatal_cause_a: assert property (
        report_nonfatal |-> |$past(unc_evt))
        else $error("non-fatal report without an event");
    cor_cause_a: assert property (report_cor |-> $past(cor_evt) != '0)
        else $error("correctable report without an event");
    gen_enable_a: assert property ($changed(crc_gen_en) |->
        $past(s_wvalid, 1) || $past(s_wvalid, 2) || $past(s_wvalid, 3))
        else $error("crc generate enable moved without a write");
    chk_enable_a: assert property ($changed(crc_chk_en) |->
        $past(s_wvalid, 1) || $past(s_wvalid, 2) || $past(s_wvalid, 3))
        else $error("crc check enable moved without a write");
    irq_rise_a: assert property ($rose(irq) |->
        act || $past(act, 1) || $past(act, 2))
        else $error("interrupt rose without cause");
    irq_fall_a: assert property ($fell(irq) |->
        s_bvalid || $past(s_bvalid, 1) || $past(s_bvalid, 2))
        else $error("interrupt fell without a write");
    read_hold_a: assert property (!$rose(s_rvalid) |-> $stable(s_rdata))
        else $error("read data moved outside a new answer");
    write_hold_a: assert property (!$rose(s_bvalid) |-> $stable(s_bresp))
        else $error("write response moved outside a new answer");
    read_block_a: assert property (s_rvalid |-> !s_arready)
        else $error("read address accepted while data pending");
endmodule : aer_monitor

bind aer_regs aer_monitor u_mon (
    .clk_sys(clk_sys), .rst_b(rst_b), .unc_evt(unc_evt), .cor_evt(cor_evt),
    .report_fatal(report_fatal), .report_nonfatal(report_nonfatal),
    .report_cor(report_cor), .crc_gen_en(crc_gen_en),
    .crc_chk_en(crc_chk_en), .irq(irq), .s_wvalid(s_wvalid),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
    .s_rready(s_rready)
);
`default_nettype wire

// File: dv/aer_root_model.sv
`timescale 1ns/1ps
`default_nettype none
module aer_root_model (
    // clock
    input wire logic clk_sys,
    // error messages from the endpoint
    input wire logic report_fatal,
    input wire logic report_nonfatal,
    input wire logic report_cor,
    // running tallies
    output logic [15:0] n_fatal,
    output logic [15:0] n_nonfatal,
    output logic [15:0] n_cor
);
    // tallies ignore endpoint resets, as a root complex log would
    initial begin
        n_fatal = '0;
        n_nonfatal = '0;
        n_cor = '0;
    end
    always @(posedge clk_sys) begin
        if (report_fatal) n_fatal <= n_fatal + 16'h1;
        if (report_nonfatal) n_nonfatal <= n_nonfatal + 16'h1;
        if (report_cor) n_cor <= n_cor + 16'h1;
    end
endmodule : aer_root_model
`default_nettype wire

// File: dv/pcie_aer_error_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module pcie_aer_error_registers_test;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [31:0] SEV_RST = 32'h00062010;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic sticky_rst_b = 1'b0;
    aer_pkg::aer_unc_evt_t unc_evt = '0;
    aer_pkg::aer_cor_evt_t cor_evt = '0;
    logic [127:0] rx_hdr = '0;
    logic [127:0] h;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic rf, rn, rc, gen_en, chk_en, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, got, v;
    logic [15:0] lfsr = 16'hA718;
    logic [15:0] ef = '0;
    logic [15:0] en = '0;
    logic [15:0] ec = '0;
    logic [15:0] mf, mn, mc;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int p;
    int cp[6] = '{0, 6, 7, 8, 12, 13};

    aer_regs u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .sticky_rst_b(sticky_rst_b), .unc_evt(unc_evt), .cor_evt(cor_evt),
        .rx_hdr(rx_hdr), .report_fatal(rf), .report_nonfatal(rn),
        .report_cor(rc), .crc_gen_en(gen_en), .crc_chk_en(chk_en),
        .irq(irq), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF),
        .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
        .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
        .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
    aer_root_model u_root (.clk_sys(clk_sys), .report_fatal(rf),
        .report_nonfatal(rn), .report_cor(rc), .n_fatal(mf),
        .n_nonfatal(mn), .n_cor(mc));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("[ERR] %0t run too long", $time);
            summarize();
        end
    end
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                resp = bresp;
                done = 1'b1;
            end
        end
    endtask : wr
    task automatic rd(input logic [11:0] a);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                got = rdata;
                resp = rresp;
                done = 1'b1;
            end
        end
    endtask : rd
    task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        `CHK(got, e)
    endtask : chk_reg
    task automatic pulse(input logic u, input int i, input logic [2:0] e);
        h = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        @(posedge clk_sys);
        if (u) unc_evt <= aer_pkg::aer_unc_evt_t'(10'h001 << i);
        else cor_evt <= aer_pkg::aer_cor_evt_t'(6'h01 << i);
        rx_hdr <= h;
        @(posedge clk_sys);
        unc_evt <= '0;
        cor_evt <= '0;
        ef = ef + 16'(e[2]);
        en = en + 16'(e[1]);
        ec = ec + 16'(e[0]);
        #1;
        `CHK({rf, rn, rc}, e)
    endtask : pulse

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        sticky_rst_b <= 1'b1;
        for (int a = 'h104; a <= 'h128; a += 4) begin
            chk_reg(12'(a), a == 'h10C ? SEV_RST : 32'h0);
        end
        rd(12'h200);
        `CHK(resp, aer_pkg::RESP_SLVERR)
        wr(12'h200, 32'h0);
        `CHK(resp, aer_pkg::RESP_SLVERR)
        wr(aer_pkg::OFS_CAP_CTRL, 32'hFFFFFFFF);
        chk_reg(aer_pkg::OFS_CAP_CTRL, 32'h00000140);
        `CHK({gen_en, chk_en}, 2'h3)
        wr(aer_pkg::OFS_CAP_CTRL, 32'h0);
        wr(aer_pkg::OFS_UNC_FATALITY, 32'hFFFFFFFF);
        chk_reg(aer_pkg::OFS_UNC_FATALITY, 32'h001FF010);
        wr(aer_pkg::OFS_UNC_FATALITY, SEV_RST);
        v = {rnd(), rnd()};
        wr(aer_pkg::OFS_COR_SUPPRESS, v);
        chk_reg(aer_pkg::OFS_COR_SUPPRESS, v & 32'h000031C1);
        wr(aer_pkg::OFS_COR_SUPPRESS, 32'h0);
        pulse(1'b0, 0, 3'h1);
        chk_reg(aer_pkg::OFS_IRQ_STATUS, 32'h4);
        `CHK(irq, 1'b0)
        wr(aer_pkg::OFS_IRQ_ENABLE, 32'hF);
        chk_reg(aer_pkg::OFS_IRQ_STATUS, 32'h4);
        `CHK(irq, 1'b1)
        wr(aer_pkg::OFS_COR_FLAGS, 32'h1);
        wr(aer_pkg::OFS_IRQ_CLEAR, 32'hF);
        chk_reg(aer_pkg::OFS_IRQ_STATUS, 32'h0);
        `CHK(irq, 1'b0)
        for (int i = 0; i < 10; i++) begin
            p = (i == 0) ? 4 : i + 11;
            pulse(1'b1, i, {~SEV_RST[p], SEV_RST[p], 1'b0});
            chk_reg(aer_pkg::OFS_UNC_FLAGS, 32'h1 << p);
            chk_reg(aer_pkg::OFS_CAP_CTRL, 32'(p));
            chk_reg(aer_pkg::OFS_HDR_WORD0, h[127:96]);
            chk_reg(aer_pkg::OFS_HDR_WORD3, h[31:0]);
            chk_reg(aer_pkg::OFS_IRQ_STATUS, {30'h2, SEV_RST[p], ~SEV_RST[p]});
            wr(aer_pkg::OFS_UNC_FLAGS, 32'h0);
            chk_reg(aer_pkg::OFS_UNC_FLAGS, 32'h1 << p);
            wr(aer_pkg::OFS_UNC_FLAGS, 32'hFFFFFFFF);
            chk_reg(aer_pkg::OFS_UNC_FLAGS, 32'h0);
            wr(aer_pkg::OFS_IRQ_CLEAR, 32'hF);
        end
        for (int i = 0; i < 6; i++) begin
            pulse(1'b0, i, 3'h1);
            chk_reg(aer_pkg::OFS_COR_FLAGS, 32'h1 << cp[i]);
            wr(aer_pkg::OFS_COR_FLAGS, 32'h1 << cp[i]);
            chk_reg(aer_pkg::OFS_COR_FLAGS, 32'h0);
        end
        wr(aer_pkg::OFS_COR_SUPPRESS, 32'h1);
        pulse(1'b0, 0, 3'h0);
        wr(aer_pkg::OFS_UNC_FATALITY, ~SEV_RST);
        pulse(1'b1, 7, 3'h4);
        v = h[127:96];
        wr(aer_pkg::OFS_UNC_FLAGS, 32'h00040000);
        wr(aer_pkg::OFS_UNC_SUPPRESS, 32'h00040000);
        pulse(1'b1, 7, 3'h0);
        chk_reg(aer_pkg::OFS_UNC_FLAGS, 32'h00040000);
        chk_reg(aer_pkg::OFS_HDR_WORD0, v);
        wr(aer_pkg::OFS_UNC_FLAGS, 32'h00040000);
        wr(aer_pkg::OFS_UNC_SUPPRESS, 32'h0);
        wr(aer_pkg::OFS_UNC_FATALITY, SEV_RST);
        pulse(1'b1, 9, 3'h4);
        v = h[127:96];
        pulse(1'b1, 0, 3'h2);
        chk_reg(aer_pkg::OFS_CAP_CTRL, 32'h14);
        chk_reg(aer_pkg::OFS_HDR_WORD0, v);
        // plain reset must leave the log alone, sticky reset must not
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        chk_reg(aer_pkg::OFS_UNC_FLAGS, 32'h0);
        chk_reg(aer_pkg::OFS_UNC_FATALITY, SEV_RST);
        chk_reg(aer_pkg::OFS_HDR_WORD0, v);
        rst_b <= 1'b0;
        sticky_rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        sticky_rst_b <= 1'b1;
        chk_reg(aer_pkg::OFS_HDR_WORD0, 32'h0);
        chk_reg(aer_pkg::OFS_CAP_CTRL, 32'h0);
        `CHK({mf, mn, mc}, {ef, en, ec})
        summarize();
    end
endmodule : pcie_aer_error_registers_test
`default_nettype wire
